// ---- src/adc_seq_regs.vh ----
// register map, field positions, reset values and timing counts
// assumes a 32-bit apb slave with byte addresses on paddr[7:0]
`ifndef ADC_SEQ_REGS_VH
`define ADC_SEQ_REGS_VH

// byte offsets of the register words
`define OFS_CTRL_ZERO 8'h00
`define OFS_CTRL_ONE 8'h04
`define OFS_RES_HIGH 8'h08
`define OFS_RES_LOW 8'h0c
`define OFS_FLAG 8'h10
`define OFS_IRQ_EN 8'h14

// adc_control_zero fields
`define BIT_ENABLE 0
`define BIT_RUN 1
`define CHS_LSB 2
`define CHS_MSB 6

// adc_control_one fields
`define CS_LSB 4
`define CS_MSB 6
`define BIT_JUSTIFY 7

// peripheral_flag_reg_one and peripheral_enable_reg_one fields
`define BIT_DONE 0
`define BIT_IRQ_EN 0

// reset values
`define RST_CTRL_ZERO 8'h00
`define RST_CTRL_ONE 8'h00
`define RST_RESULT 10'h000

// clock select codes
`define CS_DIV2 3'h0
`define CS_DIV4 3'h4
`define CS_DIV8 3'h1
`define CS_DIV16 3'h5
`define CS_DIV32 3'h2
`define CS_DIV64 3'h6
`define CS_RC_LOW 2'h3

// channel codes
`define CHS_LAST_PIN 5'h07
`define CHS_DAC 5'h1e
`define CHS_REF_BUF 5'h1f

// conversion timing in half bit periods: 11.5 periods make 23 halves
`define HALF_PER_CONV 5'd23
`define FIRST_DECIDE 5'd4
`define LAST_DECIDE 5'd22
`define SAR_TOP 10'h200

// one instruction cycle of system clocks before an rc conversion
`define INSTR_CYCLE_NS 400
`define CLK_PERIOD_NS 100
`define INSTR_CYCLES ((`INSTR_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- src/conv_tick_gen.v ----
// half bit period tick generator for the conversion clock
// assumes rc_clk_in is a level already synchronous to pclk
`timescale 1ns/1ns
module conv_tick_gen (
    input wire pclk,
    input wire presetn,
    input wire run,
    input wire [2:0] clk_sel,
    input wire rc_clk_in,
    output reg half_tick
);
`include "adc_seq_regs.vh"

    reg [5:0] div_cnt_reg;
    reg rc_prev_reg;
    wire rc_sel;
    wire [5:0] half_len;

    // half period length in system clocks for each divider code
    function [5:0] half_of;
        input [2:0] sel;
        begin
            case (sel)
                `CS_DIV2: half_of = 6'h01;
                `CS_DIV4: half_of = 6'h02;
                `CS_DIV8: half_of = 6'h04;
                `CS_DIV16: half_of = 6'h08;
                `CS_DIV32: half_of = 6'h10;
                `CS_DIV64: half_of = 6'h20;
                default: half_of = 6'h01;
            endcase
        end
    endfunction

    assign rc_sel = (clk_sel[1:0] == `CS_RC_LOW);
    assign half_len = half_of(clk_sel);

    // divider or rc edge detector, both give one tick per half period
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_reg <= 6'h00;
            rc_prev_reg <= 1'b0;
            half_tick <= 1'b0;
        end else begin
            rc_prev_reg <= rc_clk_in;
            if (!run) begin
                div_cnt_reg <= 6'h00;
                half_tick <= 1'b0;
            end else if (rc_sel) begin
                div_cnt_reg <= 6'h00;
                half_tick <= rc_clk_in ^ rc_prev_reg;
            end else if (div_cnt_reg == half_len - 6'h01) begin
                div_cnt_reg <= 6'h00;
                half_tick <= 1'b1;
            end else begin
                div_cnt_reg <= div_cnt_reg + 6'h01;
                half_tick <= 1'b0;
            end
        end
    end

endmodule // conv_tick_gen

// ---- src/sar_adc_sequencer.v ----
// control and sequencing of a 10-bit successive approximation converter
// assumes an apb master on pclk, a comparator answer on cmp_in valid at
// each decision, and core inputs sleep_in and trig_in synchronous to pclk
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ns
module sar_adc_sequencer (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output wire pslverr,
    output reg [31:0] prdata,
    input wire sleep_in,
    input wire trig_in,
    input wire rc_clk_in,
    input wire cmp_in,
    output reg [9:0] trial_code,
    output reg [4:0] channel_select,
    output reg channel_connected,
    output reg converter_powered,
    output reg sample_hold,
    output reg secondary_timer_clear,
    output reg irq_req,
    output reg wake_req
);
`include "adc_seq_regs.vh"

    localparam ST_IDLE = 3'b001;
    localparam ST_DELAY = 3'b010;
    localparam ST_CONV = 3'b100;

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg enable_reg;
    reg run_reg;
    reg run_next;
    reg [4:0] chs_reg;
    reg [2:0] conv_clock_select;
    reg justify_reg;
    reg done_flag_reg;
    reg irq_en_reg;
    reg shutdown_reg;
    reg [9:0] result_reg;
    reg [9:0] sar_reg;
    reg [9:0] bit_reg;
    reg last_bit_reg;
    reg [4:0] half_cnt_reg;
    reg [2:0] delay_cnt_reg;
    reg load_result;
    reg [9:0] result_new;
    reg done_evt;
    reg [31:0] rdata_next;
    wire half_tick;
    wire wr_acc;
    wire rd_setup;
    wire addr_ok;
    wire rc_sel;
    wire sleep_abort;
    wire start_req;
    wire decide;
    wire [9:0] sar_decided;
    wire bit_value;
    wire [7:0] res_high;
    wire [7:0] res_low;

    // decides whether a byte address is one of the register words
    function mapped;
        input [7:0] a;
        begin
            mapped = (a == `OFS_CTRL_ZERO) || (a == `OFS_CTRL_ONE) ||
                     (a == `OFS_RES_HIGH) || (a == `OFS_RES_LOW) ||
                     (a == `OFS_FLAG) || (a == `OFS_IRQ_EN);
        end
    endfunction

    // channel codes that reach a real input
    function chan_ok;
        input [4:0] c;
        begin
            chan_ok = (c <= `CHS_LAST_PIN) || (c == `CHS_DAC) || (c == `CHS_REF_BUF);
        end
    endfunction

    // partial result: bits from the trial bit down take the last decided bit
    function [9:0] fill_partial;
        input [9:0] sar;
        input [9:0] trial;
        input last;
        reg [9:0] low_mask;
        begin
            low_mask = trial | (trial - 10'h001);
            fill_partial = (sar & ~low_mask) | (last ? low_mask : 10'h000);
        end
    endfunction

    assign pready = 1'b1;
    assign addr_ok = mapped(paddr);
    assign pslverr = psel & penable & ~addr_ok;
    assign wr_acc = psel & penable & pwrite & addr_ok;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign rc_sel = (conv_clock_select[1:0] == `CS_RC_LOW);

    // bit view of the result pair
    assign res_high = justify_reg ? result_reg[9:2] : {6'h00, result_reg[9:8]};
    assign res_low = justify_reg ? {result_reg[1:0], 6'h00} : result_reg[7:0];

    // half bit period ticks from the selected conversion clock
    conv_tick_gen tick_gen (
        .pclk(pclk),
        .presetn(presetn),
        .run(state_reg == ST_CONV),
        .clk_sel(conv_clock_select),
        .rc_clk_in(rc_clk_in),
        .half_tick(half_tick)
    );

    // sleep with a system clock derived source stops the converter
    assign sleep_abort = sleep_in & ~rc_sel & enable_reg;
    assign start_req = run_reg & enable_reg & ~shutdown_reg & ~sleep_abort;

    // a bit is decided on the even half ticks from the fourth on
    assign decide = (state_reg == ST_CONV) & half_tick &
                    (half_cnt_reg >= `FIRST_DECIDE) & ~half_cnt_reg[0];
    assign bit_value = cmp_in;
    assign sar_decided = bit_value ? sar_reg : (sar_reg & ~bit_reg);

    // run bit, state and result load decisions
    always @* begin
        state_next = state_reg;
        run_next = run_reg;
        load_result = 1'b0;
        result_new = result_reg;
        done_evt = 1'b0;
        if (wr_acc && paddr == `OFS_CTRL_ZERO) begin
            run_next = pwdata[`BIT_RUN];
        end
        if (trig_in && enable_reg) begin
            run_next = 1'b1;
        end
        case (state_reg)
            ST_IDLE: begin
                if (start_req) begin
                    state_next = rc_sel ? ST_DELAY : ST_CONV;
                end
            end
            ST_DELAY: begin
                if (sleep_abort || !enable_reg) begin
                    state_next = ST_IDLE;
                    run_next = 1'b0;
                end else if (!run_next) begin
                    state_next = ST_IDLE;
                end else if (delay_cnt_reg == `INSTR_CYCLES - 1) begin
                    state_next = ST_CONV;
                end
            end
            ST_CONV: begin
                if (sleep_abort || !enable_reg) begin
                    state_next = ST_IDLE;
                    run_next = 1'b0;
                end else if (!run_next) begin
                    state_next = ST_IDLE;
                    load_result = 1'b1;
                    result_new = fill_partial(sar_reg, bit_reg, last_bit_reg);
                end else if (decide && half_cnt_reg == `LAST_DECIDE) begin
                    state_next = ST_IDLE;
                    run_next = 1'b0;
                    load_result = 1'b1;
                    result_new = sar_decided;
                    done_evt = 1'b1;
                end
            end
            default: begin
                state_next = ST_IDLE;
                run_next = 1'b0;
            end
        endcase
    end

    // control registers written by software
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_reg <= 1'b0;
            chs_reg <= 5'h00;
            conv_clock_select <= 3'h0;
            justify_reg <= 1'b0;
            irq_en_reg <= 1'b0;
        end else if (wr_acc) begin
            case (paddr)
                `OFS_CTRL_ZERO: begin
                    enable_reg <= pwdata[`BIT_ENABLE];
                    chs_reg <= pwdata[`CHS_MSB:`CHS_LSB];
                end
                `OFS_CTRL_ONE: begin
                    conv_clock_select <= pwdata[`CS_MSB:`CS_LSB];
                    justify_reg <= pwdata[`BIT_JUSTIFY];
                end
                `OFS_IRQ_EN: begin
                    irq_en_reg <= pwdata[`BIT_IRQ_EN];
                end
                default: begin
                    irq_en_reg <= irq_en_reg;
                end
            endcase
        end
    end

    // done flag: the hardware set wins over a software clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_flag_reg <= 1'b0;
        end else if (done_evt) begin
            done_flag_reg <= 1'b1;
        end else if (wr_acc && paddr == `OFS_FLAG) begin
            done_flag_reg <= pwdata[`BIT_DONE];
        end
    end

    // sequencer state, run bit and result
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            run_reg <= 1'b0;
            result_reg <= `RST_RESULT;
            delay_cnt_reg <= 3'h0;
        end else begin
            state_reg <= state_next;
            run_reg <= run_next;
            if (load_result) begin
                result_reg <= result_new;
            end
            if (state_reg == ST_DELAY) begin
                delay_cnt_reg <= delay_cnt_reg + 3'h1;
            end else begin
                delay_cnt_reg <= 3'h0;
            end
        end
    end

    // successive approximation: trial bit walks from msb to lsb
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sar_reg <= 10'h000;
            bit_reg <= 10'h000;
            last_bit_reg <= 1'b0;
            half_cnt_reg <= 5'h00;
        end else if (state_reg != ST_CONV) begin
            sar_reg <= `SAR_TOP;
            bit_reg <= `SAR_TOP;
            last_bit_reg <= 1'b0;
            half_cnt_reg <= 5'h00;
        end else if (half_tick) begin
            half_cnt_reg <= half_cnt_reg + 5'h01;
            if (decide) begin
                sar_reg <= sar_decided | (bit_reg >> 1);
                bit_reg <= bit_reg >> 1;
                last_bit_reg <= bit_value;
            end
        end
    end

    // shutdown in sleep keeps the enable bit but removes power
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shutdown_reg <= 1'b0;
        end else if (!sleep_in) begin
            shutdown_reg <= 1'b0;
        end else if (sleep_abort) begin
            shutdown_reg <= 1'b1;
        end else if (done_evt && !irq_en_reg) begin
            shutdown_reg <= 1'b1;
        end
    end

    // analog side controls and event outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trial_code <= 10'h000;
            channel_select <= 5'h00;
            channel_connected <= 1'b0;
            converter_powered <= 1'b0;
            sample_hold <= 1'b0;
            secondary_timer_clear <= 1'b0;
            irq_req <= 1'b0;
            wake_req <= 1'b0;
        end else begin
            trial_code <= sar_reg;
            channel_select <= chs_reg;
            channel_connected <= enable_reg & ~shutdown_reg & chan_ok(chs_reg);
            converter_powered <= enable_reg & ~shutdown_reg;
            sample_hold <= (state_next != ST_IDLE);
            secondary_timer_clear <= trig_in;
            irq_req <= done_flag_reg & irq_en_reg;
            wake_req <= done_flag_reg & irq_en_reg & sleep_in;
        end
    end

    // read data, captured in the setup phase
    always @* begin
        rdata_next = 32'h00000000;
        case (paddr)
            `OFS_CTRL_ZERO: begin
                rdata_next[`CHS_MSB:`CHS_LSB] = chs_reg;
                rdata_next[`BIT_RUN] = run_reg;
                rdata_next[`BIT_ENABLE] = enable_reg;
            end
            `OFS_CTRL_ONE: begin
                rdata_next[`CS_MSB:`CS_LSB] = conv_clock_select;
                rdata_next[`BIT_JUSTIFY] = justify_reg;
            end
            `OFS_RES_HIGH: rdata_next[7:0] = res_high;
            `OFS_RES_LOW: rdata_next[7:0] = res_low;
            `OFS_FLAG: rdata_next[`BIT_DONE] = done_flag_reg;
            `OFS_IRQ_EN: rdata_next[`BIT_IRQ_EN] = irq_en_reg;
            default: rdata_next = 32'h00000000;
        endcase
    end

    // prdata holds from the setup edge through the access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_setup) begin
            prdata <= rdata_next;
        end
    end

endmodule // sar_adc_sequencer

// ---- test/analog_front_end.sv ----
// comparator and rc oscillator standing at the converter's analog side
// assumes vin is set by the bench between conversions
`timescale 1ns/1ns
module analog_front_end (
    input wire logic pclk,
    input wire logic [9:0] trial_code,
    input wire logic [9:0] vin,
    output logic cmp_in,
    output logic rc_clk_in
);
    logic [1:0] div_reg = 2'h0;
    logic rc_reg = 1'b0;
    assign rc_clk_in = rc_reg;
    // keep the trial bit while the trial code does not exceed the input
    assign cmp_in = (trial_code <= vin);
    // rc level changes every four system clocks, in step with pclk
    always @(posedge pclk) begin
        div_reg <= div_reg + 2'h1;
        if (div_reg == 2'h3) begin
            rc_reg <= ~rc_reg;
        end
    end
endmodule // analog_front_end

// ---- test/sar_adc_sequencer_checker.sv ----
// port assertions for the converter sequencer
// assumes the register header on the include path; bound below
`timescale 1ns/1ns
`include "adc_seq_regs.vh"
module sar_adc_sequencer_checker (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] prdata,
    input wire pslverr,
    input wire sleep_in,
    input wire trig_in,
    input wire [9:0] trial_code,
    input wire [4:0] channel_select,
    input wire channel_connected,
    input wire converter_powered,
    input wire sample_hold,
    input wire secondary_timer_clear,
    input wire irq_req,
    input wire wake_req
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // error only in an access phase of an unmapped word
    property p_err_map;
        pslverr |-> psel && penable && (paddr > `OFS_IRQ_EN || paddr[1:0] != 2'h0);
    endproperty
    a_err_map: assert property (p_err_map) else $error("slave error on a mapped word");
    property p_wake;
        wake_req == (irq_req && $past(sleep_in));
    endproperty
    a_wake: assert property (p_wake) else $error("wake request mismatch");
    property p_trig;
        trig_in |=> secondary_timer_clear;
    endproperty
    a_trig: assert property (p_trig) else $error("timer clear missing");
    property p_trig_only;
        secondary_timer_clear |-> $past(trig_in);
    endproperty
    a_trig_only: assert property (p_trig_only) else $error("stray timer clear");
    property p_conn;
        channel_connected |-> converter_powered
            && (channel_select <= `CHS_LAST_PIN || channel_select >= `CHS_DAC);
    endproperty
    a_conn: assert property (p_conn) else $error("reserved channel connected");
    property p_rst;
        $rose(presetn) |-> !converter_powered && !sample_hold && !irq_req && trial_code == 10'h000;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    property p_start;
        $rose(sample_hold) |-> converter_powered;
    endproperty
    a_start: assert property (p_start) else $error("conversion while unpowered");
    property p_irq_fall;
        $fell(irq_req) |-> $past(psel && penable && pwrite
            && (paddr == `OFS_FLAG || paddr == `OFS_IRQ_EN), 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped by hardware");
    property p_rd_stable;
        $rose(penable) |=> $stable(prdata);
    endproperty
    a_rd_stable: assert property (p_rd_stable) else $error("read data moved in access");
    c_irq: cover property (irq_req && wake_req);
    c_done: cover property ($fell(sample_hold));
    c_err: cover property (pslverr);
endmodule // sar_adc_sequencer_checker

bind sar_adc_sequencer sar_adc_sequencer_checker chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pslverr(pslverr), .sleep_in(sleep_in), .trig_in(trig_in), .trial_code(trial_code),
    .channel_select(channel_select), .channel_connected(channel_connected),
    .converter_powered(converter_powered), .sample_hold(sample_hold),
    .secondary_timer_clear(secondary_timer_clear), .irq_req(irq_req), .wake_req(wake_req));

// ---- test/testbench.sv ----
// self-checking bench for the converter sequencer over apb
// assumes the register header and the analog side model
`timescale 1ns/1ns
`include "adc_seq_regs.vh"
module testbench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic sleep_in = 1'b0;
    logic trig_in = 1'b0;
    logic [9:0] vin = 10'h000;
    wire pready, pslverr, cmp_in, rc_clk_in, channel_connected, converter_powered;
    wire sample_hold, secondary_timer_clear, irq_req, wake_req;
    wire [31:0] prdata;
    wire [9:0] trial_code;
    wire [4:0] channel_select;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int hold_cnt = 0;
    int hold_base = 0;
    logic [31:0] rdat;
    logic rerr;
    typedef struct {logic [7:0] c1; logic [9:0] v; logic [7:0] hi; logic [7:0] lo; int h;} row_t;
    // clock select and justify, input, expected result words, half period
    row_t rows [8] = '{'{8'h00, 10'h2a5, 8'h02, 8'ha5, 1}, '{8'hc0, 10'h155, 8'h55, 8'h40, 2},
        '{8'h10, 10'h3ff, 8'h03, 8'hff, 4}, '{8'hd0, 10'h001, 8'h00, 8'h40, 8},
        '{8'h20, 10'h200, 8'h02, 8'h00, 16}, '{8'he0, 10'h1ff, 8'h7f, 8'hc0, 32},
        '{8'h30, 10'h000, 8'h00, 8'h00, 0}, '{8'hf0, 10'h37c, 8'hdf, 8'h00, 0}};

    sar_adc_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .sleep_in(sleep_in), .trig_in(trig_in), .rc_clk_in(rc_clk_in),
        .cmp_in(cmp_in), .trial_code(trial_code), .channel_select(channel_select),
        .channel_connected(channel_connected), .converter_powered(converter_powered),
        .sample_hold(sample_hold), .secondary_timer_clear(secondary_timer_clear),
        .irq_req(irq_req), .wake_req(wake_req));
    analog_front_end afe (.pclk(pclk), .trial_code(trial_code), .vin(vin), .cmp_in(cmp_in),
        .rc_clk_in(rc_clk_in));

    always #50 pclk = ~pclk;
    // cycle limit and busy time of each conversion
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (sample_hold === 1'b1)
            hold_cnt <= hold_cnt + 1;
        if (cycles == 60000) begin
            errors++;
            stop_test();
        end
    end

    task stop_test;
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; waits for pready, the cycle limit bounds the wait
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task start(input logic [7:0] c1);
        wr(`OFS_CTRL_ONE, {24'h0, c1});
        wr(`OFS_CTRL_ZERO, 32'h1);
        repeat (4) @(posedge pclk);
        hold_base = hold_cnt;
        wr(`OFS_CTRL_ZERO, 32'h3);
    endtask
    task wait_idle;
        int n;
        n = 0;
        rd(`OFS_CTRL_ZERO);
        while (rdat[1] !== 1'b0 && n < 1000) begin
            n++;
            rd(`OFS_CTRL_ZERO);
        end
        check(rdat[1], 1'b0);
    endtask

    initial begin
        int n;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // reset value of every word, then an unmapped word
        for (int i = 0; i < 6; i++) begin
            rd(8'(i * 4));
            check(rdat, 32'h0);
        end
        rd(8'h18);
        check({rdat[30:0], rerr}, 32'h1);
        // channel field reaches the mux; a reserved code connects nothing
        wr(`OFS_CTRL_ZERO, 32'h79);
        repeat (2) @(posedge pclk);
        check(channel_select, 5'h1e);
        check(channel_connected, 1'b1);
        wr(`OFS_CTRL_ZERO, 32'h21);
        repeat (2) @(posedge pclk);
        check(channel_connected, 1'b0);
        foreach (rows[i]) begin
            vin <= rows[i].v;
            start(rows[i].c1);
            wait_idle();
            rd(`OFS_RES_HIGH);
            check(rdat, {24'h0, rows[i].hi});
            rd(`OFS_RES_LOW);
            check(rdat, {24'h0, rows[i].lo});
            if (rows[i].h > 0)
                check(32'((hold_cnt - hold_base) >= 23 * rows[i].h
                    && (hold_cnt - hold_base) <= 23 * rows[i].h + 4), 1);
            rd(`OFS_FLAG);
            check(rdat, 32'h1);
            wr(`OFS_FLAG, 32'h0);
            rd(`OFS_FLAG);
            check(rdat, 32'h0);
        end
        // interrupt raised, then dropped by clearing the flag
        wr(`OFS_IRQ_EN, 32'h1);
        start(8'h00);
        wait_idle();
        check(irq_req, 1'b1);
        check(wake_req, 1'b0);
        wr(`OFS_FLAG, 32'h0);
        repeat (2) @(posedge pclk);
        check(irq_req, 1'b0);
        // rc conversion completed in sleep wakes the core
        vin <= 10'h155;
        start(8'h30);
        sleep_in <= 1'b1;
        n = 0;
        while (wake_req !== 1'b1 && n < 400) begin
            n++;
            @(posedge pclk);
        end
        check(wake_req, 1'b1);
        sleep_in <= 1'b0;
        rd(`OFS_RES_LOW);
        check(rdat, 32'h55);
        wr(`OFS_FLAG, 32'h0);
        wr(`OFS_IRQ_EN, 32'h0);
        // software abort keeps decided bits, copies the last one down
        vin <= 10'h3ff;
        start(8'h60);
        repeat (200) @(posedge pclk);
        wr(`OFS_CTRL_ZERO, 32'h1);
        rd(`OFS_RES_HIGH);
        check(rdat, 32'h3);
        rd(`OFS_RES_LOW);
        check(rdat, 32'hff);
        rd(`OFS_FLAG);
        check(rdat, 32'h0);
        // sleep with a divided clock aborts, enable still reads set
        start(8'h60);
        repeat (50) @(posedge pclk);
        sleep_in <= 1'b1;
        repeat (4) @(posedge pclk);
        check(converter_powered, 1'b0);
        rd(`OFS_CTRL_ZERO);
        check(rdat[1:0], 2'h1);
        sleep_in <= 1'b0;
        rd(`OFS_FLAG);
        check(rdat, 32'h0);
        // rc in sleep with irq off: completes, then powers down, enable kept
        start(8'h30);
        sleep_in <= 1'b1;
        n = 0;
        while (converter_powered !== 1'b0 && n < 400) begin
            n++;
            @(posedge pclk);
        end
        check(converter_powered, 1'b0);
        rd(`OFS_FLAG);
        check(rdat, 32'h1);
        rd(`OFS_CTRL_ZERO);
        check(rdat[1:0], 2'h1);
        sleep_in <= 1'b0;
        wr(`OFS_FLAG, 32'h0);
        // special event trigger starts a conversion
        wr(`OFS_CTRL_ONE, 32'h0);
        trig_in <= 1'b1;
        @(posedge pclk);
        trig_in <= 1'b0;
        wait_idle();
        rd(`OFS_FLAG);
        check(rdat, 32'h1);
        // reset in mid conversion
        start(8'h60);
        repeat (20) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(`OFS_CTRL_ZERO);
        check(rdat, 32'h0);
        check(sample_hold, 1'b0);
        stop_test();
    end
endmodule // testbench
